/* sll_defs.svh */
// Purpose: constants of the status led and light level block
// Assumes: 20 MHz clock, register offsets are modbus register numbers
// Notes:   times are kept in ns, cycle counts are derived in the modules
`ifndef SLL_DEFS_SVH
`define SLL_DEFS_SVH

// ****************************************
// timing
// ****************************************
`define SLL_CLK_NS        50
`define SLL_SEC_NS        1000000000
`define SLL_BLINK_NS      500000000
`define SLL_FLASH_NS      250000000
`define SLL_PWM_SLOT_NS   10000

// ****************************************
// register offsets
// ****************************************
`define SLL_HR_TERM       16'h0009
`define SLL_HR_ACT        16'h0023
`define SLL_HR_STBY       16'h0024
`define SLL_IR_LUX        16'h0029
`define SLL_IR_CLASS      16'h002a
`define SLL_HR_SRC        16'h004f
`define SLL_HR_BRIGHT     16'h0050

// ****************************************
// fields and reset values
// ****************************************
`define SLL_TERM_BIT      0
`define SLL_SRC_W         2
`define SLL_BRIGHT_W      4
`define SLL_TERM_RST      1'b0
`define SLL_ACT_RST       16'h012c
`define SLL_STBY_RST      16'h0032
`define SLL_SRC_RST       2'h0
`define SLL_BRIGHT_RST    4'ha
`define SLL_BRIGHT_MAX    16'h000a
`define SLL_SRC_MAX       16'h0002
`define SLL_PWM_STEPS     4'ha

`endif

/* sll_pkg.sv */
// Purpose: types of the status led and light level block
// Assumes: sll_defs.svh holds the numbers
// Notes:   measured values are treated as unsigned 16-bit codes
package sll_pkg;

   typedef enum logic [1:0] {
      SLL_SRC_CO2  = 2'h0,
      SLL_SRC_RH   = 2'h1,
      SLL_SRC_TEMP = 2'h2
   } sll_src_t;

   typedef enum logic [15:0] {
      SLL_CLASS_STANDBY = 16'h0000,
      SLL_CLASS_LOW     = 16'h0001,
      SLL_CLASS_ACTIVE  = 16'h0002
   } sll_class_t;

   typedef enum logic [1:0] {
      SLL_EXC_NONE  = 2'h0,
      SLL_EXC_ADDR  = 2'h2,
      SLL_EXC_VALUE = 2'h3
   } sll_exc_t;

   typedef enum logic [2:0] {
      SLL_RID_NONE, SLL_RID_TERM, SLL_RID_ACT, SLL_RID_STBY,
      SLL_RID_LUX, SLL_RID_CLASS, SLL_RID_SRC, SLL_RID_BRIGHT
   } sll_rid_t;

   // gray path off -> run -> lost
   typedef enum logic [1:0] {
      SLL_WD_OFF  = 2'b00,
      SLL_WD_RUN  = 2'b01,
      SLL_WD_LOST = 2'b11
   } sll_wd_t;

   typedef struct packed {
      logic        input_space;
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } sll_req_t;

   typedef struct packed {
      logic [15:0] value;
      logic [15:0] alert_lo;
      logic [15:0] alert_hi;
      logic [15:0] range_lo;
      logic [15:0] range_hi;
   } sll_var_t;

   typedef struct packed {
      sll_var_t co2;
      sll_var_t rh;
      sll_var_t temp;
   } sll_meas_t;

   typedef struct packed {
      logic green;
      logic yellow;
      logic red;
   } sll_led_t;

endpackage

/* sll_pwm.sv */
// Purpose: ten-step brightness gate shared by the three leds
// Assumes: level is 0..10, larger values act as 10
// Notes:   10 us slots give a 10 kHz led refresh, far above flicker
`timescale 1ns/1ns
`include "sll_defs.svh"

module sll_pwm (
   input  wire logic                     clock,
   input  wire logic                     rstn,
   input  wire logic [`SLL_BRIGHT_W-1:0] level,
   output logic                          on
);
   localparam int unsigned SLOT_CYC = `SLL_PWM_SLOT_NS / `SLL_CLK_NS;

   logic [15:0]              slot_reg;
   logic [`SLL_BRIGHT_W-1:0] step_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         slot_reg <= 16'h0000;
         step_reg <= 4'h0;
      end else if (slot_reg == 16'(SLOT_CYC - 1)) begin
         slot_reg <= 16'h0000;
         if (step_reg == `SLL_PWM_STEPS - 4'h1) begin
            step_reg <= 4'h0;
         end else begin
            step_reg <= step_reg + 4'h1;
         end
      end else begin
         slot_reg <= slot_reg + 16'h0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         on <= 1'b0;
      end else begin
         on <= (step_reg < level);
      end
   end

endmodule // sll_pwm

/* sll_status_light.sv */
// Purpose: status leds, brightness and ambient light classification
// Assumes: all inputs come from logic on the same clock
// Notes:   registers are reached by modbus register number and space
// Operation
// - green while selected value lies inside the alert limits
// - yellow while selected value lies in the alert range
// - yellow blinks when bus traffic stops for a nonzero timeout
// - red while selected value lies outside its measurement range
// - red blinks when an internal sensor link is lost
// - bootloader mode flashes green and yellow alternately
// - firmware upload in bootloader also flashes red
// - indication source defaults to co2, selectable rh or temperature
// - brightness 0 to 100 percent in 10 percent steps
// - measured lux readable in an input register
// - active and standby light thresholds held in holding registers
// - light below standby threshold reports standby
// - light above active threshold reports active
// - light between thresholds reports low intensity
// - termination resistor switched from a holding register
// - after power-up one led shows the selected value status
`timescale 1ns/1ns
`include "sll_defs.svh"

module sll_status_light #(
   parameter int unsigned SEC_CYC   = `SLL_SEC_NS / `SLL_CLK_NS,
   parameter int unsigned BLINK_CYC = `SLL_BLINK_NS / `SLL_CLK_NS,
   parameter int unsigned FLASH_CYC = `SLL_FLASH_NS / `SLL_CLK_NS
) (
   input  wire logic               clock,
   input  wire logic               rstn,
   input  wire sll_pkg::sll_req_t  reg_req,
   output logic [15:0]             reg_rdata,
   output logic                    reg_ack,
   output sll_pkg::sll_exc_t       reg_exc,
   input  wire sll_pkg::sll_meas_t meas,
   input  wire logic               sensor_link_lost,
   input  wire logic               modbus_frame,
   input  wire logic [15:0]        bus_timeout_setting,
   input  wire logic               bootloader_mode,
   input  wire logic               fw_upload,
   input  wire logic [15:0]        ambient_lux,
   output logic                    bus_termination_resistor,
   output sll_pkg::sll_led_t       led
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic in_win(input logic [15:0] v,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
      in_win = (v >= lo) && (v <= hi);
   endfunction

   function automatic sll_pkg::sll_rid_t decode(input logic        ispace,
                                                input logic [15:0] a);
      if (ispace && a == `SLL_IR_LUX) begin
         decode = sll_pkg::SLL_RID_LUX;
      end else if (ispace && a == `SLL_IR_CLASS) begin
         decode = sll_pkg::SLL_RID_CLASS;
      end else if (!ispace && a == `SLL_HR_TERM) begin
         decode = sll_pkg::SLL_RID_TERM;
      end else if (!ispace && a == `SLL_HR_ACT) begin
         decode = sll_pkg::SLL_RID_ACT;
      end else if (!ispace && a == `SLL_HR_STBY) begin
         decode = sll_pkg::SLL_RID_STBY;
      end else if (!ispace && a == `SLL_HR_SRC) begin
         decode = sll_pkg::SLL_RID_SRC;
      end else if (!ispace && a == `SLL_HR_BRIGHT) begin
         decode = sll_pkg::SLL_RID_BRIGHT;
      end else begin
         decode = sll_pkg::SLL_RID_NONE;
      end
   endfunction

   // ****************************************
   // registers
   // ****************************************
   logic                     term_reg;
   logic [15:0]              act_reg;
   logic [15:0]              stby_reg;
   sll_pkg::sll_src_t        src_reg;
   logic [`SLL_BRIGHT_W-1:0] bright_reg;
   logic [15:0]              lux_reg;
   sll_pkg::sll_class_t      class_reg;
   sll_pkg::sll_rid_t        rid;
   logic                     value_bad;

   always_comb begin
      rid = decode(reg_req.input_space, reg_req.addr);
      value_bad = 1'b0;
      if (rid == sll_pkg::SLL_RID_SRC) begin
         value_bad = (reg_req.wdata > `SLL_SRC_MAX);
      end else if (rid == sll_pkg::SLL_RID_BRIGHT) begin
         value_bad = (reg_req.wdata > `SLL_BRIGHT_MAX);
      end
   end

   // holding register writes; out-of-range values are refused whole
   always_ff @(posedge clock) begin
      if (!rstn) begin
         term_reg   <= `SLL_TERM_RST;
         act_reg    <= `SLL_ACT_RST;
         stby_reg   <= `SLL_STBY_RST;
         src_reg    <= sll_pkg::sll_src_t'(`SLL_SRC_RST);
         bright_reg <= `SLL_BRIGHT_RST;
      end else if (reg_req.wr && !value_bad) begin
         case (rid)
            sll_pkg::SLL_RID_TERM: begin
               term_reg <= reg_req.wdata[`SLL_TERM_BIT];
            end
            sll_pkg::SLL_RID_ACT: begin
               act_reg <= reg_req.wdata;
            end
            sll_pkg::SLL_RID_STBY: begin
               stby_reg <= reg_req.wdata;
            end
            sll_pkg::SLL_RID_SRC: begin
               src_reg <= sll_pkg::sll_src_t'(
                  reg_req.wdata[`SLL_SRC_W-1:0]);
            end
            sll_pkg::SLL_RID_BRIGHT: begin
               bright_reg <= reg_req.wdata[`SLL_BRIGHT_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // register answers
   // ****************************************
   logic [15:0] rdata_next;

   always_comb begin
      case (rid)
         sll_pkg::SLL_RID_TERM:   rdata_next = {15'h0000, term_reg};
         sll_pkg::SLL_RID_ACT:    rdata_next = act_reg;
         sll_pkg::SLL_RID_STBY:   rdata_next = stby_reg;
         sll_pkg::SLL_RID_LUX:    rdata_next = lux_reg;
         sll_pkg::SLL_RID_CLASS:  rdata_next = class_reg;
         sll_pkg::SLL_RID_SRC:    rdata_next = {14'h0000, src_reg};
         sll_pkg::SLL_RID_BRIGHT: rdata_next = {12'h000, bright_reg};
         default:                 rdata_next = 16'h0000;
      endcase
   end

   // input registers are read only, so a write there is an address fault
   always_ff @(posedge clock) begin
      if (!rstn) begin
         reg_ack   <= 1'b0;
         reg_rdata <= 16'h0000;
         reg_exc   <= sll_pkg::SLL_EXC_NONE;
      end else begin
         reg_ack   <= reg_req.wr || reg_req.rd;
         reg_rdata <= reg_req.rd ? rdata_next : 16'h0000;
         if (!(reg_req.wr || reg_req.rd)) begin
            reg_exc <= sll_pkg::SLL_EXC_NONE;
         end else if (rid == sll_pkg::SLL_RID_NONE) begin
            reg_exc <= sll_pkg::SLL_EXC_ADDR;
         end else if (reg_req.wr && reg_req.input_space) begin
            reg_exc <= sll_pkg::SLL_EXC_ADDR;
         end else if (reg_req.wr && value_bad) begin
            reg_exc <= sll_pkg::SLL_EXC_VALUE;
         end else begin
            reg_exc <= sll_pkg::SLL_EXC_NONE;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         bus_termination_resistor <= 1'b0;
      end else begin
         bus_termination_resistor <= term_reg;
      end
   end

   // ****************************************
   // ambient light
   // ****************************************
   // a level equal to a threshold counts as low intensity
   always_ff @(posedge clock) begin
      if (!rstn) begin
         lux_reg   <= 16'h0000;
         class_reg <= sll_pkg::SLL_CLASS_STANDBY;
      end else begin
         lux_reg <= ambient_lux;
         if (lux_reg < stby_reg) begin
            class_reg <= sll_pkg::SLL_CLASS_STANDBY;
         end else if (lux_reg > act_reg) begin
            class_reg <= sll_pkg::SLL_CLASS_ACTIVE;
         end else begin
            class_reg <= sll_pkg::SLL_CLASS_LOW;
         end
      end
   end

   // ****************************************
   // bus watchdog
   // ****************************************
   sll_pkg::sll_wd_t wd_reg;
   logic [31:0]      tick_reg;
   logic [15:0]      secs_reg;

   // any frame restarts the second count; ticks run freely between frames
   always_ff @(posedge clock) begin
      if (!rstn) begin
         tick_reg <= 32'h0000_0000;
         secs_reg <= 16'h0000;
      end else if (modbus_frame) begin
         tick_reg <= 32'h0000_0000;
         secs_reg <= 16'h0000;
      end else if (tick_reg == 32'(SEC_CYC - 1)) begin
         tick_reg <= 32'h0000_0000;
         if (secs_reg != 16'hffff) begin
            secs_reg <= secs_reg + 16'h0001;
         end
      end else begin
         tick_reg <= tick_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wd_reg <= sll_pkg::SLL_WD_OFF;
      end else begin
         case (wd_reg)
            sll_pkg::SLL_WD_OFF: begin
               if (bus_timeout_setting != 16'h0000) begin
                  wd_reg <= sll_pkg::SLL_WD_RUN;
               end
            end
            sll_pkg::SLL_WD_RUN: begin
               if (bus_timeout_setting == 16'h0000) begin
                  wd_reg <= sll_pkg::SLL_WD_OFF;
               end else if (!modbus_frame &&
                            secs_reg >= bus_timeout_setting) begin
                  wd_reg <= sll_pkg::SLL_WD_LOST;
               end
            end
            sll_pkg::SLL_WD_LOST: begin
               if (bus_timeout_setting == 16'h0000) begin
                  wd_reg <= sll_pkg::SLL_WD_OFF;
               end else if (modbus_frame) begin
                  wd_reg <= sll_pkg::SLL_WD_RUN;
               end
            end
            default: begin
               wd_reg <= sll_pkg::SLL_WD_OFF;
            end
         endcase
      end
   end

   // ****************************************
   // blink phases
   // ****************************************
   logic [31:0] blink_cnt_reg;
   logic [31:0] flash_cnt_reg;
   logic        blink_reg;
   logic        flash_reg;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= 1'b1;
      end else if (blink_cnt_reg == 32'(BLINK_CYC - 1)) begin
         blink_cnt_reg <= 32'h0000_0000;
         blink_reg     <= !blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 32'h0000_0001;
      end
   end

   // bootloader uses a faster flash so it is not mistaken for an alarm
   always_ff @(posedge clock) begin
      if (!rstn) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_reg     <= 1'b1;
      end else if (flash_cnt_reg == 32'(FLASH_CYC - 1)) begin
         flash_cnt_reg <= 32'h0000_0000;
         flash_reg     <= !flash_reg;
      end else begin
         flash_cnt_reg <= flash_cnt_reg + 32'h0000_0001;
      end
   end

   // ****************************************
   // indication
   // ****************************************
   sll_pkg::sll_var_t sel;
   sll_pkg::sll_led_t led_next;
   logic              out_range;
   logic              in_alert_win;
   logic              pwm_on;

   always_comb begin
      case (src_reg)
         sll_pkg::SLL_SRC_RH:   sel = meas.rh;
         sll_pkg::SLL_SRC_TEMP: sel = meas.temp;
         default:               sel = meas.co2;
      endcase
      out_range    = !in_win(sel.value, sel.range_lo, sel.range_hi);
      in_alert_win = in_win(sel.value, sel.alert_lo, sel.alert_hi);
   end

   // one branch per pattern keeps exactly one pattern on the leds
   always_comb begin
      led_next = '0;
      if (bootloader_mode) begin
         led_next.green  = flash_reg;
         led_next.yellow = !flash_reg;
         led_next.red    = fw_upload && flash_reg;
      end else if (sensor_link_lost) begin
         led_next.red = blink_reg;
      end else if (out_range) begin
         led_next.red = 1'b1;
      end else if (wd_reg == sll_pkg::SLL_WD_LOST) begin
         led_next.yellow = blink_reg;
      end else if (!in_alert_win) begin
         led_next.yellow = 1'b1;
      end else begin
         led_next.green = 1'b1;
      end
   end

   sll_pwm u_pwm (
      .clock (clock),
      .rstn  (rstn),
      .level (bright_reg),
      .on    (pwm_on)
   );

   always_ff @(posedge clock) begin
      if (!rstn) begin
         led <= '0;
      end else begin
         led.green  <= led_next.green && pwm_on;
         led.yellow <= led_next.yellow && pwm_on;
         led.red    <= led_next.red && pwm_on;
      end
   end

endmodule // sll_status_light

/* sll_monitor.sv */
// Purpose: concurrent checks on the status light block ports
// Assumes: one clock, rstn synchronous active low
// Notes:   led checks allow for the pattern and output flop pipeline
`timescale 1ns/1ns
module sll_monitor (
   input wire logic              clock,
   input wire logic              rstn,
   input wire sll_pkg::sll_req_t reg_req,
   input wire logic [15:0]       reg_rdata,
   input wire logic              reg_ack,
   input wire sll_pkg::sll_exc_t reg_exc,
   input wire logic              sensor_link_lost,
   input wire logic              bootloader_mode,
   input wire logic              fw_upload,
   input wire logic              bus_termination_resistor,
   input wire sll_pkg::sll_led_t led
);
   // ****************************************
   // checks
   // ****************************************
   logic hw;
   assign hw = reg_req.wr && !reg_req.input_space;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);

   a_ack_after_req: assert property ((reg_req.wr || reg_req.rd) |=> reg_ack)
      else $error("request not answered one cycle later");
   a_ack_needs_req: assert property (!(reg_req.wr || reg_req.rd) |=> !reg_ack)
      else $error("answer without a request");
   a_input_wr_refused: assert property ((reg_req.wr && reg_req.input_space)
      |=> reg_exc == sll_pkg::SLL_EXC_ADDR) else $error("input write taken");
   a_bright_over_refused: assert property ((hw && reg_req.addr == 16'h0050
      && reg_req.wdata > 16'h000a) |=> reg_exc == sll_pkg::SLL_EXC_VALUE)
      else $error("brightness above ten taken");
   a_term_follows_write: assert property ((hw && reg_req.addr == 16'h0009)
      |-> ##2 bus_termination_resistor == $past(reg_req.wdata[0], 2))
      else $error("termination does not follow its register");
   a_class_code_legal: assert property ((reg_req.rd && reg_req.input_space
      && reg_req.addr == 16'h002a) |=> reg_rdata <= 16'h0002)
      else $error("light class code out of range");
   a_boot_alternate: assert property (bootloader_mode |=> !(led.green && led.yellow))
      else $error("green and yellow lit together");
   a_upload_red_flash: assert property ((bootloader_mode && fw_upload) [*3]
      |=> led.red == led.green) else $error("red not flashing with upload");
   a_single_pattern: assert property (!bootloader_mode [*3] |=> $onehot0(led))
      else $error("more than one led outside bootloader");
   a_lost_red_only: assert property ((sensor_link_lost && !bootloader_mode) [*3]
      |=> !led.green && !led.yellow) else $error("sensor loss not shown in red");

   c_input_write: cover property (reg_req.wr && reg_req.input_space);
   c_upload_red: cover property (bootloader_mode && fw_upload && led.red);
   c_lost_red: cover property (sensor_link_lost && led.red);
endmodule // sll_monitor

bind sll_status_light sll_monitor MON (
   .clock(clock), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .reg_ack(reg_ack), .reg_exc(reg_exc), .sensor_link_lost(sensor_link_lost),
   .bootloader_mode(bootloader_mode), .fw_upload(fw_upload),
   .bus_termination_resistor(bus_termination_resistor), .led(led));

/* sll_master_model.sv */
// Purpose: bus master model issuing register requests and frame pulses
// Assumes: one request per call, answer sampled one cycle after taking
// Notes:   gap inserts idle cycles to act as a slow master
`timescale 1ns/1ns
module sll_master_model (
   input  wire logic              clock,
   input  wire logic [15:0]       reg_rdata,
   input  wire logic              reg_ack,
   input  wire sll_pkg::sll_exc_t reg_exc,
   output sll_pkg::sll_req_t      reg_req,
   output logic                   modbus_frame
);
   // ****************************************
   // transfers
   // ****************************************
   initial begin
      reg_req = '0;
      modbus_frame = 1'b0;
   end

   task automatic xfer(input logic sp, input logic [15:0] a, d,
                       input logic w, input int gap, output logic [15:0] rd,
                       output sll_pkg::sll_exc_t ex, output logic ak);
      repeat (gap) @(posedge clock);
      @(posedge clock);
      reg_req <= '{sp, a, d, w, !w};
      @(posedge clock);
      reg_req <= '0;
      #1;
      ak = reg_ack;
      rd = reg_rdata;
      ex = reg_exc;
   endtask

   task automatic frame();
      @(posedge clock);
      modbus_frame <= 1'b1;
      @(posedge clock);
      modbus_frame <= 1'b0;
   endtask
endmodule // sll_master_model

/* sll_tb.sv */
// Purpose: self-checking bench of the status light block
// Assumes: shortened second, blink and flash counts
// Notes:   led counts are taken over whole blink or pwm periods
`timescale 1ns/1ns
module testbench;
   // ****************************************
   // environment
   // ****************************************
   logic               clock, rstn, sensor_link_lost, modbus_frame;
   logic               bootloader_mode, fw_upload, term, reg_ack;
   logic [15:0]        bus_timeout_setting, ambient_lux, reg_rdata;
   sll_pkg::sll_req_t  reg_req;
   sll_pkg::sll_exc_t  reg_exc;
   sll_pkg::sll_meas_t meas;
   sll_pkg::sll_led_t  led;
   int                 errors = 0, checks = 0;
   logic [31:0]        g, y, r, gy, rg;

   sll_status_light #(.SEC_CYC(20), .BLINK_CYC(8), .FLASH_CYC(4)) DUT (
      .clock(clock), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_exc(reg_exc), .meas(meas),
      .sensor_link_lost(sensor_link_lost), .modbus_frame(modbus_frame),
      .bus_timeout_setting(bus_timeout_setting),
      .bootloader_mode(bootloader_mode), .fw_upload(fw_upload),
      .ambient_lux(ambient_lux), .bus_termination_resistor(term), .led(led));
   sll_master_model MASTER (.clock(clock), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_exc(reg_exc), .reg_req(reg_req),
      .modbus_frame(modbus_frame));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // unselected variables sit out of range so a wrong selection shows red
   function automatic sll_pkg::sll_meas_t mk(int s, logic [15:0] val);
      sll_pkg::sll_var_t v [3];
      for (int i = 0; i < 3; i++) begin
         v[i] = '{(i == s) ? val : 16'd400, 16'd100, 16'd200, 16'd50, 16'd300};
      end
      return '{v[0], v[1], v[2]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic sp, input logic [15:0] a, d, input logic w,
                      input logic [1:0] ee, input logic [15:0] ed, input int gp);
      logic [15:0]       rd;
      sll_pkg::sll_exc_t ex;
      logic              ak;
      MASTER.xfer(sp, a, d, w, gp, rd, ex, ak);
      chk(ak, 1'b1);
      chk(ex, ee);
      chk(rd, ed);
   endtask

   // counts are logic so an unknown led poisons the comparison
   task automatic see(input int n);
      g = 0; y = 0; r = 0; gy = 0; rg = 0;
      repeat (n + 4) @(posedge clock);
      repeat (n) begin
         @(posedge clock);
         #1;
         g = g + led.green;
         y = y + led.yellow;
         r = r + led.red;
         gy = gy + (led.green == led.yellow);
         rg = rg + (led.red != led.green);
      end
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      logic [16:0] ra [7] = '{17'h00009, 17'h00023, 17'h00024, 17'h0004f,
                              17'h00050, 17'h10029, 17'h1002a};
      logic [15:0] rv [7] = '{16'h0, 16'h012c, 16'h0032, 16'h0, 16'h000a,
                              16'h0, 16'h0};
      see(8);
      chk(g, 8);
      for (int i = 0; i < 7; i++) acc(ra[i][16], ra[i][15:0], 0, 0, 0, rv[i], i);
      acc(0, 16'h0030, 0, 0, 2'h2, 0, 0);
      acc(0, 16'h0029, 0, 0, 2'h2, 0, 0);
   endtask

   task automatic t_sources();
      logic [15:0] vals [4] = '{16'd150, 16'd70, 16'd400, 16'd40};
      for (int s = 0; s < 3; s++) begin
         acc(0, 16'h004f, s, 1, 0, 0, 0);
         for (int k = 0; k < 4; k++) begin
            @(posedge clock);
            meas <= mk(s, vals[k]);
            see(8);
            chk(g, (k == 0) ? 8 : 0);
            chk(y, (k == 1) ? 8 : 0);
            chk(r, (k >= 2) ? 8 : 0);
         end
      end
      acc(0, 16'h004f, 16'h0003, 1, 2'h3, 0, 0);
      acc(0, 16'h004f, 0, 1, 0, 0, 1);
      @(posedge clock);
      meas <= mk(0, 16'd150);
   endtask

   task automatic t_faults();
      @(posedge clock);
      sensor_link_lost <= 1'b1;
      see(32);
      chk(r, 16);
      chk(g + y, 0);
      @(posedge clock);
      sensor_link_lost <= 1'b0;
      bus_timeout_setting <= 16'h0001;
      MASTER.frame();
      repeat (45) @(posedge clock);
      see(32);
      chk(y, 16);
      chk(g + r, 0);
      MASTER.frame();
      see(8);
      chk(g, 8);
      @(posedge clock);
      bus_timeout_setting <= 16'h0000;
      repeat (45) @(posedge clock);
      see(8);
      chk(g, 8);
   endtask

   task automatic t_boot();
      @(posedge clock);
      bootloader_mode <= 1'b1;
      sensor_link_lost <= 1'b1;
      see(16);
      chk(g, 8);
      chk(gy, 0);
      chk(r, 0);
      @(posedge clock);
      fw_upload <= 1'b1;
      see(16);
      chk(gy, 0);
      chk(rg, 0);
      chk(r, 8);
      @(posedge clock);
      {bootloader_mode, fw_upload, sensor_link_lost} <= 3'h0;
   endtask

   task automatic t_regs();
      logic [15:0] lx [4] = '{16'h007f, 16'h0080, 16'h0100, 16'h0101};
      logic [15:0] cl [4] = '{16'h0, 16'h1, 16'h1, 16'h2};
      acc(0, 16'h0009, 16'hffff, 1, 0, 0, 0);
      acc(0, 16'h0009, 0, 0, 0, 16'h0001, 0);
      chk(term, 1'b1);
      acc(0, 16'h0009, 16'h0000, 1, 0, 0, 0);
      @(posedge clock);
      #1;
      chk(term, 1'b0);
      acc(1, 16'h0029, 16'h0005, 1, 2'h2, 0, 0);
      acc(0, 16'h0023, 16'h0100, 1, 0, 0, 0);
      acc(0, 16'h0024, 16'h0080, 1, 0, 0, 0);
      acc(0, 16'h0023, 0, 0, 0, 16'h0100, 0);
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         ambient_lux <= lx[i];
         acc(1, 16'h0029, 0, 0, 0, lx[i], 3);
         acc(1, 16'h002a, 0, 0, 0, cl[i], 0);
      end
   endtask

   task automatic t_bright();
      logic [15:0] bl [3] = '{16'h0005, 16'h0000, 16'h000a};
      for (int i = 0; i < 3; i++) begin
         acc(0, 16'h0050, bl[i], 1, 0, 0, 0);
         see(2000);
         chk(g, bl[i] * 200);
      end
      acc(0, 16'h0050, 16'h000b, 1, 2'h3, 0, 0);
      acc(0, 16'h0050, 0, 0, 0, 16'h000a, 0);
   endtask

   task automatic end_sim();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      #(50 * 40000);
      errors++;
      end_sim();
   end

   initial begin
      rstn = 1'b0;
      {sensor_link_lost, bootloader_mode, fw_upload} = 3'h0;
      bus_timeout_setting = 16'h0;
      ambient_lux = 16'h0;
      meas = mk(0, 16'd150);
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_reset();
      t_sources();
      t_faults();
      t_boot();
      t_regs();
      t_bright();
      end_sim();
   end
endmodule // testbench
